// file: design/io_ports_pkg.sv
// Package with addresses, field positions and reset values of the port block
package io_ports_pkg;

  // ----------------------------------------------------------------
  // Register-file and memory-mapped addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BIDIR_DATA = 8'h02;   // Bidirectional port data
  localparam logic [7:0] ADDR_MIXED_DATA = 8'h03;   // Mixed port data
  localparam logic [7:0] ADDR_BIDIR_MODE = 8'hf6;   // Direction, write-only
  localparam logic [7:0] ADDR_MIXED_MODE = 8'hf7;   // Mixed config, write-only
  localparam logic [15:0] ADDR_LED_PORT = 16'hfc31; // LED output port
  localparam logic [15:0] ADDR_SENSE_PORT = 16'hfc32; // Sensing input port

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WAKE_BIT = 0;       // Mixed data bit of the wake pin
  localparam int TIMER_BIT = 1;      // Mixed data bit of the timer pin
  localparam int OUT_A_BIT = 4;      // Mixed data bit of plain output a
  localparam int OUT_B_BIT = 5;      // Mixed data bit of plain output b
  localparam int MUXED_BIT = 6;      // Mixed data bit of the muxed pin
  localparam int OPEN_DRAIN_BIT = 0; // Mixed mode: bidir port open-drain
  localparam int MUX_SEL_LSB = 1;    // Mixed mode: muxed pin source select
  localparam int SENSE_PINS = 6;     // Number of sensing pins

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BIDIR_MODE_RST = 8'hff; // All lines inputs
  localparam logic [7:0] MIXED_MODE_RST = 8'h00; // Push-pull, gp bit
  localparam logic [7:0] DATA_RST = 8'h00;       // Output data registers

  // Muxed output sources
  typedef enum logic [1:0] {
    MUX_GP,
    MUX_TIMER,
    MUX_SCLK
  } mux_sel_t;

  // Register-file and external-memory access kinds
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_RF_WRITE,
    ACC_EXT_WRITE
  } acc_kind_t;

endpackage

// file: design/edge_if.sv
// Interface carrying a synchronised pin and its falling-edge pulse
`timescale 1ns/1ns
`default_nettype none
interface edge_if;
  logic level;  // Synchronised pin level
  logic fall;   // One-cycle pulse on a falling edge
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface
`default_nettype wire

// file: design/edge_sense.sv
// Two-stage synchroniser with falling-edge detector for one pin
`timescale 1ns/1ns
`default_nettype none
module edge_sense (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Pin
  input wire logic pin_i,
  // Result
  edge_if.src sense
);

  // ----------------------------------------------------------------
  // Synchroniser and edge detect
  // ----------------------------------------------------------------
  logic meta_reg;   // First stage, read only by the second
  logic sync_reg;   // Second stage
  logic last_reg;   // Previous synchronised level

  // Pins idle high, so reset all stages high to avoid a false edge
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign sense.level = sync_reg;
  assign sense.fall = last_reg & ~sync_reg;

endmodule
`default_nettype wire

// file: design/tv_controller_io_ports.sv
// Parallel I/O port logic of a television controller
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [R1] Eight bidirectional lines, per-bit direction
// [R2] Outputs push-pull or open-drain, one global setting
// [R3] Wake pin readable; falling edge sets request
// [R4] Wake pin rising in stop starts recovery
// [R5] Timer pin readable; falling edge sets request
// [R6] Timer pin level feeds timer input
// [R7] Two plain outputs drive their port bits
// [R8] Muxed pin: port bit, timer or clock
// [R9] Eight LED lines drive last written value
// [R10] Six sensing inputs read as low bits
// [R11] Comparator outputs read as bits 6, 7
// [R12] Bidir and mixed ports in register file
// [R13] LED at FC31, sensing at FC32 externally
// [R14] Mode registers write-only at F6, F7
// [R15] Edge inputs synchronised before edge detect
// [R16] Reset: bidir inputs, muxed pin general-purpose
module tv_controller_io_ports (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register file access from the processor
  input wire logic rf_wr_i,
  input wire logic [7:0] rf_addr_i,
  input wire logic [7:0] rf_wdata_i,
  output logic [7:0] rf_rdata_o,
  // External memory access from the processor
  input wire logic ext_wr_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic [7:0] ext_wdata_i,
  output logic [7:0] ext_rdata_o,
  // Bidirectional port pins
  input wire logic [7:0] bidir_port_lines_i,
  output logic [7:0] bidir_port_lines_o,
  output logic [7:0] bidir_port_lines_oe_o,
  // Mixed port pins
  input wire logic wake_edge_pin_i,
  input wire logic timer_edge_pin_i,
  output logic plain_out_a_o,
  output logic plain_out_b_o,
  output logic muxed_out_pin_o,
  // LED and sensing ports
  output logic [7:0] led_port_lines_o,
  input wire logic [5:0] sense_port_lines_i,
  input wire logic [1:0] fine_tune_comparator_input_i,
  // Links to the rest of the device
  input wire logic stop_mode_i,
  input wire logic timer_output_i,
  input wire logic sclk_level_i,
  output logic wake_edge_request_o,
  output logic timer_edge_request_o,
  output logic timer_ext_input_o,
  output logic stop_recover_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] bidir_data_reg;   // Bidir output data
  logic [7:0] mixed_data_reg;   // Mixed output data
  logic [7:0] bidir_mode_reg;   // 1 = input
  logic [7:0] mixed_mode_reg;   // Open-drain and mux select
  logic [7:0] led_reg;          // LED port value
  logic wake_prev_reg;          // Wake level in the previous cycle
  edge_if wake_sense ();        // Wake pin sensing
  edge_if timer_sense ();       // Timer pin sensing
  logic [1:0] mux_sel;          // Selected muxed source

  // Register-file write strobe for one address
  function automatic logic rf_hit(input logic wr, input logic [7:0] a,
                                  input logic [7:0] target);
    rf_hit = wr && (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Edge sensing
  // ----------------------------------------------------------------
  // Both edge inputs go through a synchroniser first (see [R15])
  edge_sense u_wake (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(wake_edge_pin_i),
    .sense(wake_sense)
  );
  edge_sense u_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(timer_edge_pin_i),
    .sense(timer_sense)
  );

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  // Write-only mode registers; reset makes all lines inputs (see [R14])
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bidir_mode_reg <= io_ports_pkg::BIDIR_MODE_RST; // see [R16]
      mixed_mode_reg <= io_ports_pkg::MIXED_MODE_RST; // see [R16]
    end else begin
      if (rf_hit(rf_wr_i, rf_addr_i, io_ports_pkg::ADDR_BIDIR_MODE)) begin
        bidir_mode_reg <= rf_wdata_i; // see [R1]
      end
      if (rf_hit(rf_wr_i, rf_addr_i, io_ports_pkg::ADDR_MIXED_MODE)) begin
        mixed_mode_reg <= rf_wdata_i; // see [R14]
      end
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Bidir and mixed data live in the register file (see [R12])
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bidir_data_reg <= io_ports_pkg::DATA_RST;
      mixed_data_reg <= io_ports_pkg::DATA_RST;
    end else begin
      if (rf_hit(rf_wr_i, rf_addr_i, io_ports_pkg::ADDR_BIDIR_DATA)) begin
        bidir_data_reg <= rf_wdata_i; // see [R12]
      end
      if (rf_hit(rf_wr_i, rf_addr_i, io_ports_pkg::ADDR_MIXED_DATA)) begin
        mixed_data_reg <= rf_wdata_i; // see [R12]
      end
    end
  end

  // LED port, written only through external memory (see [R13])
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      led_reg <= io_ports_pkg::DATA_RST;
    end else if (ext_wr_i && ext_addr_i == io_ports_pkg::ADDR_LED_PORT) begin
      led_reg <= ext_wdata_i; // see [R9]
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Register-file read; mode registers read as zero (see [R14])
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rf_rdata_o <= 8'h00;
    end else begin
      case (rf_addr_i)
        io_ports_pkg::ADDR_BIDIR_DATA: begin
          // Inputs show the pin, outputs the written data
          rf_rdata_o <= (bidir_mode_reg & bidir_port_lines_i) |
                        (~bidir_mode_reg & bidir_data_reg); // see [R1]
        end
        io_ports_pkg::ADDR_MIXED_DATA: begin
          rf_rdata_o <= mixed_data_reg;
          rf_rdata_o[io_ports_pkg::WAKE_BIT] <= wake_sense.level; // see [R3]
          rf_rdata_o[io_ports_pkg::TIMER_BIT] <= timer_sense.level; // see [R5]
        end
        default: begin
          rf_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // External read of LED and sensing ports
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ext_rdata_o <= 8'h00;
    end else begin
      case (ext_addr_i)
        io_ports_pkg::ADDR_LED_PORT: begin
          ext_rdata_o <= led_reg;
        end
        io_ports_pkg::ADDR_SENSE_PORT: begin
          // Six pins low, comparators above (see [R10]) (see [R11])
          ext_rdata_o <= {fine_tune_comparator_input_i, sense_port_lines_i};
        end
        default: begin
          ext_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign mux_sel =
    mixed_mode_reg[io_ports_pkg::MUX_SEL_LSB +: $bits(io_ports_pkg::mux_sel_t)];

  // Bidir drive: open-drain enables only for zeros (see [R2])
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bidir_port_lines_o <= 8'h00;
      bidir_port_lines_oe_o <= 8'h00; // see [R16]
    end else begin
      bidir_port_lines_o <= bidir_data_reg;
      if (mixed_mode_reg[io_ports_pkg::OPEN_DRAIN_BIT]) begin
        bidir_port_lines_oe_o <= ~bidir_mode_reg & ~bidir_data_reg; // see [R2]
      end else begin
        bidir_port_lines_oe_o <= ~bidir_mode_reg; // see [R1]
      end
    end
  end

  // Mixed and LED outputs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      plain_out_a_o <= 1'b0;
      plain_out_b_o <= 1'b0;
      muxed_out_pin_o <= 1'b0;
      led_port_lines_o <= 8'h00;
    end else begin
      plain_out_a_o <= mixed_data_reg[io_ports_pkg::OUT_A_BIT]; // see [R7]
      plain_out_b_o <= mixed_data_reg[io_ports_pkg::OUT_B_BIT]; // see [R7]
      led_port_lines_o <= led_reg; // see [R9]
      case (mux_sel)
        io_ports_pkg::MUX_TIMER: muxed_out_pin_o <= timer_output_i; // see [R8]
        io_ports_pkg::MUX_SCLK: muxed_out_pin_o <= sclk_level_i; // see [R8]
        default: muxed_out_pin_o <= mixed_data_reg[io_ports_pkg::MUXED_BIT];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Events to the rest of the device
  // ----------------------------------------------------------------
  // One-cycle request pulses on falling edges, timer level passed on
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wake_edge_request_o <= 1'b0;
      timer_edge_request_o <= 1'b0;
      timer_ext_input_o <= 1'b0;
      wake_prev_reg <= 1'b1;
      stop_recover_o <= 1'b0;
    end else begin
      wake_edge_request_o <= wake_sense.fall; // see [R3]
      timer_edge_request_o <= timer_sense.fall; // see [R5]
      timer_ext_input_o <= timer_sense.level; // see [R6]
      wake_prev_reg <= wake_sense.level;
      // Recovery pulse when wake pin rises during stop
      stop_recover_o <= stop_mode_i & wake_sense.level &
                        ~wake_prev_reg; // see [R4]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wake_req;
    @(posedge clock_i) disable iff (!rst_n_i)
      $fell(wake_sense.level) |=> wake_edge_request_o;
  endproperty
  a_wake_req: assert property (p_wake_req) // see [R3]
    else $error("wake request missing");

  property p_timer_req;
    @(posedge clock_i) disable iff (!rst_n_i)
      timer_edge_request_o |-> !timer_ext_input_o;
  endproperty
  a_timer_req: assert property (p_timer_req) // see [R5]
    else $error("timer request with high level");

  property p_timer_fall;
    @(posedge clock_i) disable iff (!rst_n_i)
      $fell(timer_sense.level) |=> timer_edge_request_o;
  endproperty
  a_timer_fall: assert property (p_timer_fall) // see [R5]
    else $error("timer request missing");

  property p_single_req;
    @(posedge clock_i) disable iff (!rst_n_i)
      wake_edge_request_o |=> !wake_edge_request_o;
  endproperty
  a_single_req: assert property (p_single_req) // see [R15]
    else $error("wake request longer than one cycle");

  property p_recover;
    @(posedge clock_i) disable iff (!rst_n_i)
      stop_recover_o |-> $past(stop_mode_i) && $past(wake_sense.level) &&
                         !$past(wake_prev_reg);
  endproperty
  a_recover: assert property (p_recover) // see [R4]
    else $error("recovery without high wake level");

  property p_plain;
    @(posedge clock_i) disable iff (!rst_n_i)
      $changed(mixed_data_reg[io_ports_pkg::OUT_A_BIT]) |=>
        plain_out_a_o == $past(mixed_data_reg[io_ports_pkg::OUT_A_BIT]);
  endproperty
  a_plain: assert property (p_plain) // see [R7]
    else $error("plain output wrong");

  property p_led;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ext_wr_i && ext_addr_i == io_ports_pkg::ADDR_LED_PORT) |=> ##1
        led_port_lines_o == $past(ext_wdata_i, 2);
  endproperty
  a_led: assert property (p_led) // see [R9]
    else $error("LED port not updated");

  property p_od;
    @(posedge clock_i) disable iff (!rst_n_i)
      mixed_mode_reg[io_ports_pkg::OPEN_DRAIN_BIT] |=>
        (bidir_port_lines_oe_o & bidir_port_lines_o) == 8'h00;
  endproperty
  a_od: assert property (p_od) // see [R2]
    else $error("open-drain drives high");

  property p_dir;
    @(posedge clock_i) disable iff (!rst_n_i)
      1'b1 |=> (bidir_port_lines_oe_o & $past(bidir_mode_reg)) == 8'h00;
  endproperty
  a_dir: assert property (p_dir) // see [R1]
    else $error("input line driven");

  c_wake: cover property (@(posedge clock_i) wake_edge_request_o);
  c_recover: cover property (@(posedge clock_i) stop_recover_o);
  c_od: cover property (@(posedge clock_i)
    |bidir_port_lines_oe_o && mixed_mode_reg[io_ports_pkg::OPEN_DRAIN_BIT]);

endmodule
`default_nettype wire

// file: bench/board_model.sv
// Board circuitry facing the bidirectional port: pull-ups and switches
`timescale 1ns/1ns
`default_nettype none
module board_model (
  // Port side
  input wire logic [7:0] drive_i,
  input wire logic [7:0] enable_i,
  // Board side
  input wire logic [7:0] switch_closed_i,
  output logic [7:0] level_o
);
  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // A driven line shows the port; a released one the pull-up,
  // unless its switch shorts it to ground
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level_o[i] = enable_i[i] ? drive_i[i] : ~switch_closed_i[i];
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_tv_controller_io_ports.sv
// Self-checking testbench of the television controller port block
`timescale 1ns/1ns
`default_nettype none
module tb_tv_controller_io_ports;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rf_wr_i = 1'b0;
  logic [7:0] rf_addr_i = 8'h00;
  logic [7:0] rf_wdata_i = 8'h00;
  logic [7:0] rf_rdata_o;
  logic ext_wr_i = 1'b0;
  logic [15:0] ext_addr_i = 16'h0000;
  logic [7:0] ext_wdata_i = 8'h00;
  logic [7:0] ext_rdata_o;
  logic [7:0] bidir_port_lines_i, bidir_port_lines_o, bidir_port_lines_oe_o;
  logic wake_edge_pin_i = 1'b1;
  logic timer_edge_pin_i = 1'b1;
  logic plain_out_a_o, plain_out_b_o, muxed_out_pin_o;
  logic [7:0] led_port_lines_o;
  logic [5:0] sense_port_lines_i = 6'h15;
  logic [1:0] fine_tune_comparator_input_i = 2'h2;
  logic stop_mode_i = 1'b0;
  logic timer_output_i = 1'b1;
  logic sclk_level_i = 1'b1;
  logic wake_edge_request_o, timer_edge_request_o;
  logic timer_ext_input_o, stop_recover_o;
  logic [7:0] switch_closed = 8'h0f; // Switches pulling lines low
  // Behavioural model state
  logic [7:0] m_dir, m_data, m_oe, m_pin, rd;
  logic m_mux;                // Expected muxed pin level
  logic [7:0] led_hist[$];    // Every value written to the LED port
  int wake_cnt = 0, timer_cnt = 0, rec_cnt = 0;
  int bad_count = 0, compares = 0;

  // ------------------------------------------------------------
  // Design, board and clock
  // ------------------------------------------------------------
  tv_controller_io_ports dut_u (.clock_i, .rst_n_i, .rf_wr_i, .rf_addr_i,
    .rf_wdata_i, .rf_rdata_o, .ext_wr_i, .ext_addr_i, .ext_wdata_i,
    .ext_rdata_o, .bidir_port_lines_i, .bidir_port_lines_o,
    .bidir_port_lines_oe_o, .wake_edge_pin_i, .timer_edge_pin_i,
    .plain_out_a_o, .plain_out_b_o, .muxed_out_pin_o, .led_port_lines_o,
    .sense_port_lines_i, .fine_tune_comparator_input_i, .stop_mode_i,
    .timer_output_i, .sclk_level_i, .wake_edge_request_o,
    .timer_edge_request_o, .timer_ext_input_o, .stop_recover_o);
  board_model board_u (.drive_i(bidir_port_lines_o),
    .enable_i(bidir_port_lines_oe_o), .switch_closed_i(switch_closed),
    .level_o(bidir_port_lines_i));
  always #4 clock_i = ~clock_i;

  // Count one-cycle pulses at each sampling edge
  always @(posedge clock_i) begin
    if (wake_edge_request_o === 1'b1) wake_cnt++;
    if (timer_edge_request_o === 1'b1) timer_cnt++;
    if (stop_recover_o === 1'b1) rec_cnt++;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input string n, input logic [15:0] s,
                       input logic [15:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write, then let the store and the output stage settle
  task automatic rf_write(input logic [7:0] a, input logic [7:0] d);
    rf_addr_i = a;
    rf_wdata_i = d;
    rf_wr_i = 1'b1;
    tick(1);
    rf_wr_i = 1'b0;
    tick(3);
  endtask
  task automatic ext_write(input logic [15:0] a, input logic [7:0] d);
    ext_addr_i = a;
    ext_wdata_i = d;
    ext_wr_i = 1'b1;
    tick(1);
    ext_wr_i = 1'b0;
    tick(3);
  endtask
  task automatic rf_read(input logic [7:0] a, output logic [7:0] d);
    rf_addr_i = a;
    tick(2);
    d = rf_rdata_o;
  endtask
  task automatic ext_read(input logic [15:0] a, output logic [7:0] d);
    ext_addr_i = a;
    tick(2);
    d = ext_rdata_o;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests take
  initial begin
    #40000;
    bad_count++;
    $display("watchdog expired");
    conclude();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(53));
    tick(20);
    rst_n_i = 1'b1;
    tick(2);
    // Reset state: lines are inputs, muxed pin on its port bit
    check("oe after reset", bidir_port_lines_oe_o, 0);
    check("muxed after reset", muxed_out_pin_o, 0);
    rf_read(io_ports_pkg::ADDR_BIDIR_DATA, rd);
    m_pin = ~switch_closed;
    check("bidir read after reset", rd, m_pin);
    rf_read(io_ports_pkg::ADDR_BIDIR_MODE, rd);
    check("mode read", rd, 0);
    $display("test reset done");
    // Direction, data and drive kind on random patterns
    for (int i = 0; i < 8; i++) begin
      m_dir = 8'($urandom);
      m_data = 8'($urandom);
      switch_closed = 8'($urandom);
      rf_write(io_ports_pkg::ADDR_MIXED_MODE, {7'h00, i[0]});
      rf_write(io_ports_pkg::ADDR_BIDIR_MODE, m_dir);
      rf_write(io_ports_pkg::ADDR_BIDIR_DATA, m_data);
      m_oe = i[0] ? ~m_dir & ~m_data : ~m_dir;
      m_pin = (m_oe & m_data) | (~m_oe & ~switch_closed);
      check("bidir oe", bidir_port_lines_oe_o, m_oe);
      check("bidir out", bidir_port_lines_o & m_oe, m_data & m_oe);
      check("bidir pin", bidir_port_lines_i, m_pin);
      rf_read(io_ports_pkg::ADDR_BIDIR_DATA, rd);
      m_pin = (m_dir & m_pin) | (~m_dir & m_data);
      check("bidir read", rd, m_pin);
    end
    $display("test bidirectional port done");
    // Reset in mid-run returns every line to input, muxed pin to its bit
    rst_n_i = 1'b0;
    tick(3);
    rst_n_i = 1'b1;
    tick(2);
    check("oe after mid reset", bidir_port_lines_oe_o, 0);
    check("muxed after mid reset", muxed_out_pin_o, 0);
    $display("test mid-run reset done");
    // Every muxed source, with plain outputs alongside
    for (int s = 0; s < 4; s++) begin
      m_data = 8'($urandom);
      timer_output_i = 1'($urandom);
      sclk_level_i = ~timer_output_i;
      rf_write(io_ports_pkg::ADDR_MIXED_MODE, {5'h00, s[1:0], 1'b0});
      rf_write(io_ports_pkg::ADDR_MIXED_DATA, m_data);
      m_mux = s == 1 ? timer_output_i : s == 2 ? sclk_level_i : m_data[6];
      check("plain a", plain_out_a_o, m_data[4]);
      check("plain b", plain_out_b_o, m_data[5]);
      check("muxed", muxed_out_pin_o, m_mux);
    end
    $display("test mixed outputs done");
    // LED writes, refused writes, sensing reads, unmapped reads
    for (int i = 0; i < 4; i++) begin
      m_data = 8'($urandom);
      sense_port_lines_i = 6'($urandom);
      fine_tune_comparator_input_i = 2'($urandom);
      led_hist.push_back(m_data);
      ext_write(io_ports_pkg::ADDR_LED_PORT, m_data);
      check("led", led_port_lines_o, led_hist[$]);
      ext_write(io_ports_pkg::ADDR_SENSE_PORT, ~m_data);
      rf_write(8'h31, ~m_data);
      check("led kept", led_port_lines_o, led_hist[$]);
      ext_read(io_ports_pkg::ADDR_SENSE_PORT, rd);
      m_pin = {fine_tune_comparator_input_i, sense_port_lines_i};
      check("sense", rd, m_pin);
      ext_read(16'hfc33, rd);
      check("unmapped", rd, 0);
    end
    $display("test memory-mapped ports done");
    // Falling edges, timer level, stop recovery
    wake_cnt = 0;
    timer_cnt = 0;
    rec_cnt = 0;
    wake_edge_pin_i = 1'b0;
    timer_edge_pin_i = 1'b0;
    tick(8);
    check("wake requests", 16'(wake_cnt), 1);
    check("timer requests", 16'(timer_cnt), 1);
    check("timer level low", timer_ext_input_o, 0);
    rf_read(io_ports_pkg::ADDR_MIXED_DATA, rd);
    check("edge pins low", rd[1:0], 0);
    stop_mode_i = 1'b1;
    wake_edge_pin_i = 1'b1;
    timer_edge_pin_i = 1'b1;
    tick(8);
    check("recoveries", 16'(rec_cnt), 1);
    check("wake on rise", 16'(wake_cnt), 1);
    check("timer level high", timer_ext_input_o, 1);
    rf_read(io_ports_pkg::ADDR_MIXED_DATA, rd);
    check("edge pins high", rd[1:0], 2'h3);
    stop_mode_i = 1'b0;
    wake_edge_pin_i = 1'b0;
    tick(8);
    wake_edge_pin_i = 1'b1;
    tick(8);
    check("no recovery out of stop", 16'(rec_cnt), 1);
    check("second wake request", 16'(wake_cnt), 2);
    $display("test edge pins done");
    conclude();
  end
endmodule
`default_nettype wire
